// *** include/spdfuel_pkg.sv ***
// constants, field layouts and state types for the speed reference and fuel limiter
`default_nettype none
package spdfuel_pkg;
	// ==========================================================
	// widths and scaling
	localparam int RPM_W = 16;
	localparam int FUEL_W = 16;
	localparam int FRAC_W = 8;
	localparam int REF_W = RPM_W + FRAC_W;
	localparam int NPTS = 5;
	localparam logic [FUEL_W-1:0] FUEL_FULL = 16'h2710;
	localparam logic [15:0] CAL_UNITY = 16'h1000;
	localparam int CAL_SHIFT = 12;
	localparam int VOLT_SHIFT = 2;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int PID_SETTLE_S = 1;
	localparam int PID_SETTLE_MS = PID_SETTLE_S * 1000;
	localparam int BUMP_ARM_MIN = 30;
	localparam int BUMP_ARM_MS = BUMP_ARM_MIN * 60 * 1000;
	// ==========================================================
	// percentages of speed
	localparam int PCT_BASE = 100;
	localparam int CRANK_PCT = 5;
	localparam int NEAR_REF_PCT = 95;
	// ==========================================================
	// contact bit positions in the synchroniser vector
	localparam int NCON = 6;
	localparam int C_RAISE = 5;
	localparam int C_LOWER = 4;
	localparam int C_RATED = 3;
	localparam int C_REMOTE = 2;
	localparam int C_BUMP_EN = 1;
	localparam int C_BUMP_TRIG = 0;
	// ==========================================================
	// types
	typedef enum logic [1:0] {REF_START, REF_RAMP, REF_RUN} ref_mode_t;
	typedef struct packed {
		logic [NPTS-1:0][RPM_W-1:0] x;
		logic [NPTS-1:0][FUEL_W-1:0] y;
	} curve_t;
	typedef struct packed {
		logic [NCON-1:0] sync1;
		logic [NCON-1:0] sync2;
		logic [NCON-1:0] prev;
		logic [16:0] tick_cnt;
		ref_mode_t mode;
		logic [REF_W-1:0] ref_val;
		logic crank;
		logic [15:0] stall_cnt;
		logic stall_on;
		logic [15:0] warm_cnt;
		logic warm_done;
		logic [FUEL_W-1:0] start_lim;
		logic start_on;
		logic [10:0] settle_cnt;
		logic [20:0] arm_cnt;
		logic armed;
		logic [15:0] bump_cnt;
		logic bump_on;
		logic [FUEL_W-1:0] torque_lim;
		logic [FUEL_W-1:0] press_lim;
		logic [15:0] press_ma;
		logic [15:0] press_disp;
		logic [FUEL_W-1:0] fuel;
	} state_t;
endpackage : spdfuel_pkg
`default_nettype wire

// *** design/curve_interp.sv ***
// five point piecewise linear curve lookup
`default_nettype none
module curve_interp
	import spdfuel_pkg::*;
(
	// curve input and table
	input wire logic [RPM_W-1:0] x_i,
	input wire curve_t curve_i,
	// interpolated limit
	output logic [FUEL_W-1:0] y_o
);
	// ==========================================================
	// segment search and interpolation
	logic signed [33:0] dy;
	logic [16:0] dx;
	logic [16:0] px;
	logic done;
	always_comb begin
		y_o = curve_i.y[NPTS-1];
		dy = '0;
		dx = '0;
		px = '0;
		done = 1'b0;
		if (x_i <= curve_i.x[0]) begin
			y_o = curve_i.y[0];
			done = 1'b1;
		end
		for (int i = 0; i < NPTS - 1; i++) begin
			// breakpoints are assumed rising; a flat segment returns its left value
			if (!done && x_i < curve_i.x[i+1]) begin
				dx = {1'b0, curve_i.x[i+1]} - {1'b0, curve_i.x[i]};
				px = {1'b0, x_i} - {1'b0, curve_i.x[i]};
				dy = ($signed({18'h0, curve_i.y[i+1]}) - $signed({18'h0, curve_i.y[i]}))
					* $signed({17'h0, px});
				if (dx != '0) begin
					dy = dy / $signed({17'h0, dx});
				end else begin
					dy = '0;
				end
				y_o = 16'(($signed({18'h0, curve_i.y[i]}) + dy));
				done = 1'b1;
			end
		end
	end
endmodule : curve_interp
`default_nettype wire

// *** design/speed_reference_fuel_limiter.sv ***
// speed reference generator and fuel demand limiter chain
// ==========================================================
// Summary of operation
// - raise and remote capped at upper limit
// - lower and remote floored at lower limit
// - open idle/rated contact ramps to idle
// - hold start speed, then ramp to selection
// - stall bypass for start time after cranking
// - closed contact ramps idle to rated
// - opened contact ramps rated to idle
// - increases in run move at raise rate only
// - decreases in run move at lower rate only
// - warm-up done after delay at running
// - start limit full, then start fuel
// - start limit ramps, ends near reference
// - zero start rate freezes start limit
// - fuel always capped at maximum limit
// - channel offset and span calibration
// - volt display flag divides milliamps
// - bump enable arms for thirty minutes
// - bump caps fuel at full minus level for duration
// - speed curve interpolated over five points
// - speed curve off means no cap
// - pressure curve cap, bypassed when off
`default_nettype none
module speed_reference_fuel_limiter
	import spdfuel_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int BUMP_ARM_TICKS = BUMP_ARM_MS
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// contacts from pins
	input wire logic raise_i,
	input wire logic lower_i,
	input wire logic rated_sel_i,
	input wire logic remote_sel_i,
	input wire logic bump_enable_i,
	input wire logic bump_trigger_i,
	// measurements and permissives
	input wire logic [RPM_W-1:0] speed_i,
	input wire logic [15:0] remote_raw_i,
	input wire logic [15:0] pressure_raw_i,
	input wire logic [FUEL_W-1:0] pid_demand_i,
	input wire logic pid_in_control_i,
	input wire logic rated_permit_i,
	input wire logic idle_permit_i,
	// speed settings
	input wire logic [RPM_W-1:0] upper_limit_i,
	input wire logic [RPM_W-1:0] lower_limit_i,
	input wire logic [RPM_W-1:0] idle_speed_i,
	input wire logic [RPM_W-1:0] rated_speed_i,
	input wire logic [RPM_W-1:0] start_speed_i,
	input wire logic [15:0] start_time_i,
	input wire logic [15:0] up_ramp_duration_i,
	input wire logic [15:0] down_ramp_duration_i,
	input wire logic [15:0] raise_rate_i,
	input wire logic [15:0] lower_rate_i,
	input wire logic [15:0] warm_delay_i,
	// fuel limiter settings
	input wire logic [FUEL_W-1:0] start_fuel_i,
	input wire logic [15:0] start_rate_i,
	input wire logic [FUEL_W-1:0] max_fuel_i,
	input wire logic [FUEL_W-1:0] bump_level_i,
	input wire logic [15:0] disturb_length_i,
	input wire logic speed_curve_cap_on_i,
	input wire curve_t speed_curve_point_i,
	input wire logic pressure_curve_cap_on_i,
	input wire curve_t pressure_curve_point_i,
	// calibration
	input wire logic [15:0] pressure_offset_i,
	input wire logic [15:0] pressure_span_i,
	input wire logic pressure_volt_display_i,
	input wire logic [15:0] remote_offset_i,
	input wire logic [15:0] remote_span_i,
	// results
	output logic [RPM_W-1:0] speed_ref_o,
	output logic [FUEL_W-1:0] fuel_demand_o,
	output logic stall_bypass_o,
	output logic warm_done_o,
	output logic start_limit_on_o,
	output logic bump_armed_o,
	output logic bump_active_o,
	output logic [15:0] pressure_display_o
);
	// ==========================================================
	// helpers
	function automatic logic pct_ge(input logic [15:0] a, input logic [15:0] b,
		input int pct);
		return (32'(a) * 32'(PCT_BASE)) >= (32'(b) * 32'(pct));
	endfunction : pct_ge

	function automatic logic [REF_W-1:0] ramp_step(input logic [15:0] hi,
		input logic [15:0] lo, input logic [15:0] dur);
		logic [REF_W-1:0] q;
		q = (hi > lo) ? {hi - lo, 8'h00} : '0;
		q = q / REF_W'((dur == 16'h0) ? 16'h1 : dur);
		return (q == '0) ? REF_W'(1) : q;
	endfunction : ramp_step

	function automatic logic [REF_W-1:0] move(input logic [REF_W-1:0] cur,
		input logic [REF_W-1:0] tgt, input logic [REF_W-1:0] up, input logic [REF_W-1:0] dn);
		if (cur < tgt) begin
			return (tgt - cur > up) ? cur + up : tgt;
		end else begin
			return (cur - tgt > dn) ? cur - dn : tgt;
		end
	endfunction : move

	function automatic logic [15:0] cal(input logic [15:0] raw, input logic [15:0] off,
		input logic [15:0] span);
		logic [31:0] p;
		p = (raw > off) ? 32'(raw - off) * 32'(span) : 32'h0;
		p = p >> CAL_SHIFT;
		return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
	endfunction : cal

	function automatic logic [FUEL_W-1:0] fmin(input logic [FUEL_W-1:0] a,
		input logic [FUEL_W-1:0] b);
		return (a < b) ? a : b;
	endfunction : fmin

	// ==========================================================
	// curve lookups
	state_t state_reg;
	state_t state_next;
	logic [FUEL_W-1:0] torque_y;
	logic [FUEL_W-1:0] press_y;
	curve_interp u_speed_curve (
		.x_i(speed_i),
		.curve_i(speed_curve_point_i),
		.y_o(torque_y)
	);
	curve_interp u_press_curve (
		.x_i(state_reg.press_ma),
		.curve_i(pressure_curve_point_i),
		.y_o(press_y)
	);

	// ==========================================================
	// next state
	logic tick;
	logic rated_sel;
	logic [REF_W-1:0] tgt;
	logic [REF_W-1:0] up_lim;
	logic [REF_W-1:0] lo_lim;
	logic [REF_W-1:0] rem;
	logic [16:0] slim;
	logic [FUEL_W-1:0] bump_cap;
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = {raise_i, lower_i, rated_sel_i, remote_sel_i,
			bump_enable_i, bump_trigger_i};
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;
		tick = state_reg.tick_cnt == 17'(TICK_CYC - 1);
		state_next.tick_cnt = tick ? '0 : state_reg.tick_cnt + 17'h1;
		rated_sel = state_reg.sync2[C_RATED];
		up_lim = {upper_limit_i, 8'h00};
		lo_lim = {lower_limit_i, 8'h00};
		rem = {cal(remote_raw_i, remote_offset_i, remote_span_i), 8'h00};
		tgt = state_reg.ref_val;
		slim = '0;
		// ------------------------------------------------------
		// speed reference
		state_next.crank = pct_ge(speed_i, rated_speed_i, CRANK_PCT);
		case (state_reg.mode)
			REF_START: begin
				state_next.ref_val = {start_speed_i, 8'h00};
				if (speed_i >= start_speed_i) begin
					state_next.mode = REF_RAMP;
				end
			end
			REF_RAMP: begin
				if (rated_sel && rated_permit_i) begin
					tgt = {rated_speed_i, 8'h00};
				end else if (!rated_sel && idle_permit_i) begin
					tgt = {idle_speed_i, 8'h00};
				end
				if (tick) begin
					state_next.ref_val = move(state_reg.ref_val, tgt,
						ramp_step(rated_speed_i, idle_speed_i, up_ramp_duration_i),
						ramp_step(rated_speed_i, idle_speed_i, down_ramp_duration_i));
				end
				if (state_reg.ref_val == {rated_speed_i, 8'h00} && rated_sel) begin
					state_next.mode = REF_RUN;
				end
			end
			REF_RUN: begin
				if (!rated_sel && idle_permit_i) begin
					state_next.mode = REF_RAMP;
				end else begin
					if (state_reg.sync2[C_REMOTE]) begin
						tgt = rem;
					end else if (state_reg.sync2[C_RAISE]) begin
						tgt = up_lim;
					end else if (state_reg.sync2[C_LOWER]) begin
						tgt = lo_lim;
					end
					if (tgt > up_lim) begin
						tgt = up_lim;
					end
					if (tgt < lo_lim) begin
						tgt = lo_lim;
					end
					if (tick) begin
						state_next.ref_val = move(state_reg.ref_val, tgt,
							REF_W'(raise_rate_i), REF_W'(lower_rate_i));
					end
				end
			end
			default: state_next.mode = REF_START;
		endcase
		// engine stopped: back to the start speed
		if (!state_reg.crank && state_reg.mode != REF_START) begin
			state_next.mode = REF_START;
		end
		// ------------------------------------------------------
		// stall bypass after cranking
		if (!state_next.crank) begin
			state_next.stall_cnt = '0;
			state_next.stall_on = 1'b0;
		end else if (!state_reg.crank) begin
			state_next.stall_cnt = start_time_i;
			state_next.stall_on = start_time_i != 16'h0;
		end else if (tick && state_reg.stall_cnt != '0) begin
			state_next.stall_cnt = state_reg.stall_cnt - 16'h1;
			state_next.stall_on = state_reg.stall_cnt != 16'h1;
		end
		// ------------------------------------------------------
		// warm-up delay
		if (speed_i < idle_speed_i) begin
			state_next.warm_cnt = '0;
			state_next.warm_done = 1'b0;
		end else if (tick && !state_reg.warm_done) begin
			if (state_reg.warm_cnt >= warm_delay_i) begin
				state_next.warm_done = 1'b1;
			end else begin
				state_next.warm_cnt = state_reg.warm_cnt + 16'h1;
			end
		end
		// ------------------------------------------------------
		// start fuel limiter
		if (!state_next.crank) begin
			state_next.start_lim = FUEL_FULL;
			state_next.start_on = 1'b0;
			state_next.settle_cnt = '0;
		end else if (!state_reg.crank) begin
			state_next.start_lim = start_fuel_i;
			state_next.start_on = 1'b1;
		end else if (state_reg.start_on && tick) begin
			// a zero rate adds nothing, leaving the fixed start fuel
			slim = 17'(state_reg.start_lim) + 17'(start_rate_i);
			state_next.start_lim = (slim > 17'(FUEL_FULL)) ? FUEL_FULL : slim[15:0];
			if (pct_ge(speed_i, state_reg.ref_val[REF_W-1:FRAC_W], NEAR_REF_PCT)
				&& pid_in_control_i) begin
				state_next.settle_cnt = state_reg.settle_cnt + 11'h1;
			end else begin
				state_next.settle_cnt = '0;
			end
			if (state_reg.settle_cnt == 11'(PID_SETTLE_MS - 1)) begin
				state_next.start_on = 1'b0;
				state_next.start_lim = FUEL_FULL;
			end
		end
		// ------------------------------------------------------
		// fuel bump: arm on enable edge, fire on trigger falling edge
		if (!state_reg.sync2[C_BUMP_EN]) begin
			state_next.arm_cnt = '0;
		end else if (!state_reg.prev[C_BUMP_EN]) begin
			state_next.arm_cnt = 21'(BUMP_ARM_TICKS);
		end else if (tick && state_reg.arm_cnt != '0) begin
			state_next.arm_cnt = state_reg.arm_cnt - 21'h1;
		end
		state_next.armed = state_next.arm_cnt != '0;
		if (state_reg.bump_on) begin
			if (tick) begin
				state_next.bump_cnt = state_reg.bump_cnt - 16'h1;
				state_next.bump_on = state_reg.bump_cnt > 16'h1;
			end
		end else if (state_reg.arm_cnt != '0 && state_reg.prev[C_BUMP_TRIG]
			&& !state_reg.sync2[C_BUMP_TRIG] && disturb_length_i != 16'h0) begin
			state_next.bump_cnt = disturb_length_i;
			state_next.bump_on = 1'b1;
		end
		bump_cap = (bump_level_i > FUEL_FULL) ? '0 : FUEL_FULL - bump_level_i;
		// ------------------------------------------------------
		// curve caps, calibration and final selection
		state_next.torque_lim = speed_curve_cap_on_i ? torque_y : FUEL_FULL;
		state_next.press_lim = pressure_curve_cap_on_i ? press_y : FUEL_FULL;
		state_next.press_ma = cal(pressure_raw_i, pressure_offset_i, pressure_span_i);
		state_next.press_disp = pressure_volt_display_i ?
			(state_reg.press_ma >> VOLT_SHIFT) : state_reg.press_ma;
		state_next.fuel = fmin(fmin(fmin(pid_demand_i, state_reg.start_lim),
			fmin(max_fuel_i, state_reg.bump_on ? bump_cap : FUEL_FULL)),
			fmin(state_reg.torque_lim, state_reg.press_lim));
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
			state_reg.start_lim <= FUEL_FULL;
			state_reg.torque_lim <= FUEL_FULL;
			state_reg.press_lim <= FUEL_FULL;
		end else begin
			state_reg <= state_next;
		end
	end

	assign speed_ref_o = state_reg.ref_val[REF_W-1:FRAC_W];
	assign fuel_demand_o = state_reg.fuel;
	assign stall_bypass_o = state_reg.stall_on;
	assign warm_done_o = state_reg.warm_done;
	assign start_limit_on_o = state_reg.start_on;
	assign bump_armed_o = state_reg.armed;
	assign bump_active_o = state_reg.bump_on;
	assign pressure_display_o = state_reg.press_disp;

	// ==========================================================
	// checks
	a_ref_upper: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.mode == REF_RUN && $past(state_reg.mode) == REF_RUN && upper_limit_i >= lower_limit_i
		&& $stable(upper_limit_i) && $past(state_reg.ref_val) <= {upper_limit_i, 8'h00}
		|-> state_reg.ref_val <= {upper_limit_i, 8'h00})
		else $error("reference above upper limit");
	a_ref_lower: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.mode == REF_RUN && $past(state_reg.mode) == REF_RUN && $stable(lower_limit_i)
		&& $past(state_reg.ref_val) >= {lower_limit_i, 8'h00}
		|-> state_reg.ref_val >= {lower_limit_i, 8'h00})
		else $error("reference below lower limit");
	a_start_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.mode == REF_START && state_next.mode == REF_START && state_reg.crank
		|=> state_reg.ref_val == {$past(start_speed_i), 8'h00})
		else $error("start speed not held");
	a_stall_window: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!state_reg.crank && state_next.crank && start_time_i != 16'h0
		|=> stall_bypass_o && state_reg.stall_cnt == $past(start_time_i))
		else $error("stall bypass not started");
	a_start_cut: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$rose(state_reg.crank) |-> state_reg.start_lim == $past(start_fuel_i))
		else $error("start fuel not applied at speed clear");
	a_max_cap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$stable(max_fuel_i) |=> fuel_demand_o <= $past(max_fuel_i, 2))
		else $error("fuel above maximum limit");
	a_lowest_term: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		1'b1 |=> fuel_demand_o <= $past(pid_demand_i)
		&& fuel_demand_o <= $past(state_reg.torque_lim))
		else $error("fuel above a limiting term");
	a_raise_rate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.mode == REF_RUN && $past(state_reg.mode) == REF_RUN
		&& state_reg.ref_val > $past(state_reg.ref_val)
		|-> state_reg.ref_val - $past(state_reg.ref_val) <= REF_W'($past(raise_rate_i)))
		else $error("reference stepped faster than raise rate");
	a_bump_cut: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		state_reg.bump_on && bump_level_i <= FUEL_FULL && $stable(bump_level_i)
		|=> fuel_demand_o <= FUEL_FULL - $past(bump_level_i))
		else $error("bump cut not applied");
	a_torque_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!speed_curve_cap_on_i |=> state_reg.torque_lim == FUEL_FULL)
		else $error("speed curve cap active while off");
endmodule : speed_reference_fuel_limiter
`default_nettype wire

// *** bench/engine_model.sv ***
// engine speed model facing the governor
`default_nettype none
module engine_model
	import spdfuel_pkg::*;
#(
	parameter int SLEW = 50
) (
	input wire logic clock_i,
	input wire logic [RPM_W-1:0] target_i,
	input wire logic [FUEL_W-1:0] fuel_i,
	output logic [RPM_W-1:0] speed_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int diff;
	initial speed_o = 16'h0000;
	// ==========================================================
	// speed slews toward target; no fuel means no acceleration
	// stepping on the rising edge by nba keeps clear of the bench's falling-edge writes
	always @(posedge clock_i) begin
		diff = int'(target_i) - int'(speed_o);
		if (diff > SLEW) diff = SLEW;
		if (diff < -SLEW) diff = -SLEW;
		if (diff > 0 && fuel_i == 16'h0000) diff = 0;
		speed_o <= RPM_W'(int'(speed_o) + diff);
	end
endmodule : engine_model
`default_nettype wire

// *** bench/speed_reference_fuel_limiter_test.sv ***
// self-checking bench for the speed reference and fuel limiter
`default_nettype none
module speed_reference_fuel_limiter_test;
	import spdfuel_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// stimulus and results
	localparam int TK = 10;
	typedef struct {
		logic [15:0] pid, mx;
		logic tq, pr;
		logic [15:0] spd, praw, span;
		logic volt;
		logic [15:0] fuel, disp;
	} row_t;
	row_t rows[7] = '{
		'{16'h1388, 16'h2710, 1'b0, 1'b0, 16'h06a4, 16'h01f4, 16'h1000, 1'b0, 16'h1388, 16'h01f4},
		'{16'h2328, 16'h1b58, 1'b0, 1'b0, 16'h06a4, 16'h01f4, 16'h1000, 1'b0, 16'h1b58, 16'h01f4},
		'{16'h251c, 16'h2710, 1'b1, 1'b0, 16'h05dc, 16'h01f4, 16'h1000, 1'b0, 16'h2134, 16'h01f4},
		'{16'h251c, 16'h2710, 1'b0, 1'b0, 16'h05dc, 16'h01f4, 16'h1000, 1'b0, 16'h251c, 16'h01f4},
		'{16'h251c, 16'h2710, 1'b0, 1'b1, 16'h06a4, 16'h01f4, 16'h2000, 1'b0, 16'h2134, 16'h03e8},
		'{16'h251c, 16'h2710, 1'b0, 1'b0, 16'h06a4, 16'h01f4, 16'h2000, 1'b0, 16'h251c, 16'h03e8},
		'{16'h251c, 16'h2710, 1'b0, 1'b0, 16'h06a4, 16'h01f4, 16'h1000, 1'b1, 16'h251c, 16'h007d}};
	logic [15:0] rem_raw[3] = '{16'h0758, 16'h0a28, 16'h00c8};
	logic [15:0] rem_exp[3] = '{16'h06f4, 16'h073a, 16'h06a4};
	int errors = 0;
	int compares = 0;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic raise_i = 1'b0;
	logic lower_i = 1'b0;
	logic rated_sel_i = 1'b0;
	logic remote_sel_i = 1'b0;
	logic bump_enable_i = 1'b0;
	logic bump_trigger_i = 1'b0;
	logic [15:0] speed_i;
	logic [15:0] target = 16'h0000;
	logic [15:0] remote_raw_i = 16'h0000;
	logic [15:0] pressure_raw_i = 16'h01f4;
	logic [15:0] pid_demand_i = 16'h2328;
	logic pid_in_control_i = 1'b0;
	logic rated_permit_i = 1'b1;
	logic idle_permit_i = 1'b1;
	logic [15:0] upper_limit_i = 16'h073a;
	logic [15:0] lower_limit_i = 16'h06a4;
	logic [15:0] idle_speed_i = 16'h03e8;
	logic [15:0] rated_speed_i = 16'h0708;
	logic [15:0] start_speed_i = 16'h012c;
	logic [15:0] start_time_i = 16'h001e;
	logic [15:0] up_ramp_duration_i = 16'h0064;
	logic [15:0] down_ramp_duration_i = 16'h0032;
	logic [15:0] raise_rate_i = 16'h0500;
	logic [15:0] lower_rate_i = 16'h0500;
	logic [15:0] warm_delay_i = 16'h0014;
	logic [15:0] start_fuel_i = 16'h2710;
	logic [15:0] start_rate_i = 16'h0000;
	logic [15:0] max_fuel_i = 16'h2710;
	logic [15:0] bump_level_i = 16'h07d0;
	logic [15:0] disturb_length_i = 16'h000a;
	logic speed_curve_cap_on_i = 1'b0;
	curve_t speed_curve_point_i;
	logic pressure_curve_cap_on_i = 1'b0;
	curve_t pressure_curve_point_i;
	logic [15:0] pressure_offset_i = 16'h0000;
	logic [15:0] pressure_span_i = 16'h1000;
	logic pressure_volt_display_i = 1'b0;
	logic [15:0] remote_offset_i = 16'h0064;
	logic [15:0] remote_span_i = 16'h1000;
	logic [15:0] speed_ref_o, fuel_demand_o, pressure_display_o;
	logic stall_bypass_o, warm_done_o, start_limit_on_o, bump_armed_o, bump_active_o;
	// ==========================================================
	// design and engine
	speed_reference_fuel_limiter #(.TICK_CYC(TK), .BUMP_ARM_TICKS(50)) i_dut (.*);
	engine_model i_engine (
		.clock_i(clock_i),
		.target_i(target),
		.fuel_i(fuel_demand_o),
		.speed_o(speed_i)
	);
	initial begin
		forever #10 clock_i = ~clock_i;
	end
	// ==========================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic tk(input int n);
		cyc(n * TK);
	endtask : tk
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		compares++;
		if (a !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
		end
	endtask : chk
	task automatic chkb(input logic a, input logic e);
		chk({15'h0000, a}, {15'h0000, e});
	endtask : chkb
	task automatic rst();
		sys_rst_i = 1'b1;
		cyc(10);
		chk(fuel_demand_o, 16'h0000);
		chk(speed_ref_o, 16'h0000);
		sys_rst_i = 1'b0;
		cyc(1);
		chk(speed_ref_o, start_speed_i);
	endtask : rst
	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// ==========================================================
	// watchdog: whole run is about 16k cycles
	initial begin
		repeat (40000) @(posedge clock_i);
		errors++;
		results();
	end
	// ==========================================================
	// main sequence
	initial begin
		for (int i = 0; i < NPTS; i++) begin
			speed_curve_point_i.x[i] = 16'h03e8 * 16'(i);
			speed_curve_point_i.y[i] = 16'h2710 - 16'h03e8 * 16'(i);
			pressure_curve_point_i.x[i] = 16'h0190 * 16'(i + 1);
			pressure_curve_point_i.y[i] = 16'h2710 - 16'h03e8 * 16'(i);
		end
		rst();
		// start limit parked at full so only the table terms bite
		for (int i = 0; i < 7; i++) begin
			pid_demand_i = rows[i].pid;
			max_fuel_i = rows[i].mx;
			speed_curve_cap_on_i = rows[i].tq;
			pressure_curve_cap_on_i = rows[i].pr;
			target = rows[i].spd;
			pressure_raw_i = rows[i].praw;
			pressure_span_i = rows[i].span;
			pressure_volt_display_i = rows[i].volt;
			cyc(20);
			chk(fuel_demand_o, rows[i].fuel);
			chk(pressure_display_o, rows[i].disp);
		end
		$display("table done");
		pid_demand_i = 16'h2328;
		start_fuel_i = 16'h0bb8;
		target = 16'h0000;
		cyc(40);
		rst();
		cyc(5);
		chk(fuel_demand_o, pid_demand_i);
		target = 16'h0190;
		cyc(12);
		chkb(stall_bypass_o, 1'b1);
		chk(fuel_demand_o, start_fuel_i);
		tk(20);
		chkb(speed_ref_o > start_speed_i && speed_ref_o < idle_speed_i, 1'b1);
		tk(80);
		chk(speed_ref_o, idle_speed_i);
		chkb(stall_bypass_o, 1'b0);
		chk(fuel_demand_o, start_fuel_i);
		chkb(warm_done_o, 1'b0);
		target = idle_speed_i;
		tk(10);
		chkb(warm_done_o, 1'b0);
		tk(15);
		chkb(warm_done_o, 1'b1);
		rated_sel_i = 1'b1;
		tk(50);
		chkb(speed_ref_o > idle_speed_i && speed_ref_o < rated_speed_i, 1'b1);
		tk(60);
		chk(speed_ref_o, rated_speed_i);
		target = rated_speed_i;
		pid_in_control_i = 1'b1;
		tk(990);
		chkb(start_limit_on_o, 1'b1);
		tk(20);
		chkb(start_limit_on_o, 1'b0);
		chk(fuel_demand_o, pid_demand_i);
		$display("start done");
		raise_i = 1'b1;
		tk(4);
		chkb(speed_ref_o > rated_speed_i && speed_ref_o <= 16'h071c, 1'b1);
		tk(20);
		chk(speed_ref_o, upper_limit_i);
		raise_i = 1'b0;
		lower_i = 1'b1;
		tk(4);
		chkb(speed_ref_o < upper_limit_i && speed_ref_o >= 16'h0726, 1'b1);
		tk(40);
		chk(speed_ref_o, lower_limit_i);
		lower_i = 1'b0;
		remote_sel_i = 1'b1;
		for (int i = 0; i < 3; i++) begin
			remote_raw_i = rem_raw[i];
			tk(2);
			chkb(speed_ref_o != rem_exp[i], 1'b1);
			tk(40);
			chk(speed_ref_o, rem_exp[i]);
		end
		remote_sel_i = 1'b0;
		$display("setting done");
		bump_enable_i = 1'b1;
		cyc(5);
		chkb(bump_armed_o, 1'b1);
		for (int i = 0; i < 2; i++) begin
			bump_trigger_i = 1'b1;
			cyc(5);
			bump_trigger_i = 1'b0;
			cyc(8);
			chkb(bump_active_o, i == 0);
			chk(fuel_demand_o, i == 0 ? 16'h1f40 : pid_demand_i);
			tk(i == 0 ? 12 : 0);
			chkb(bump_active_o, 1'b0);
			tk(i == 0 ? 45 : 0);
			chkb(bump_armed_o, 1'b0);
		end
		bump_enable_i = 1'b0;
		$display("bump done");
		rated_sel_i = 1'b0;
		idle_permit_i = 1'b0;
		tk(5);
		chk(speed_ref_o, lower_limit_i);
		idle_permit_i = 1'b1;
		tk(5);
		chkb(speed_ref_o < lower_limit_i && speed_ref_o > idle_speed_i, 1'b1);
		tk(50);
		chk(speed_ref_o, idle_speed_i);
		// second reset mid-run with the engine still turning
		start_rate_i = 16'h0064;
		rst();
		tk(10);
		chkb(fuel_demand_o > start_fuel_i && fuel_demand_o <= 16'h1068, 1'b1);
		$display("restart done");
		results();
	end
endmodule : speed_reference_fuel_limiter_test
`default_nettype wire
